// *** rtl/reset_controller.v ***
`timescale 1ns/1ps
`include "reset_controller_defines.vh"

// Overview of operation
// - Hold stage keeps system reset until supply and clocks settle.
// - Reset pin is filtered; short low pulses are discarded.
// - Power-on detector pulse raises a hardware reset request.
// - Enabled key-entry pins held low long enough request reset.
// - Watchdog overflow raises a reset request.
// - Voltage detector resets only when its reset function is enabled.
// - Peripheral soft reset bit resets that peripheral's control bits.
// - Module enable bit may have no reset effect per peripheral.
// - Three groups: wide hardware, pin and power, software.
// - A group resets whenever any of its sources requests.
// - Wide hardware group released only after the hold time.
// - Software group released at once when request ends.
module reset_controller #(
   parameter HOLD_CYCLES = `HOLD_CYCLES,
   parameter PIN_CYCLES = `PIN_FILTER_CYCLES,
   parameter KEY_CYCLES = `KEY_FILTER_CYCLES,
   parameter NUM_PERIPH = `NUM_PERIPH,
   parameter [NUM_PERIPH-1:0] ENABLE_RESETS = {NUM_PERIPH{1'b1}}
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // External pins
   input wire reset_pin_n,
   input wire [1:0] key_pins_n,
   input wire key_reset_enable,
   // Internal sources
   input wire power_on_detect,
   input wire watchdog_overflow,
   input wire voltage_drop_detect,
   input wire voltage_reset_enable,
   // Peripheral software reset bits
   input wire [NUM_PERIPH-1:0] module_enable_bit,
   input wire [NUM_PERIPH-1:0] peripheral_soft_reset_bit,
   // Group resets, active low
   output reg hw_reset_group_wide_n,
   output reg hw_reset_group_pin_power_n,
   output reg [NUM_PERIPH-1:0] sw_reset_group_n
);

   // ****************************************
   // Synchronisers
   // ****************************************
   reg pin_meta;
   reg pin_sync;
   reg [1:0] key_meta;
   reg [1:0] key_sync;
   reg por_meta;
   reg por_sync;

   always @(posedge clk) begin
      if (!rst_b) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         key_meta <= 2'h3;
         key_sync <= 2'h3;
         por_meta <= 1'b0;
         por_sync <= 1'b0;
      end else begin
         pin_meta <= reset_pin_n;
         pin_sync <= pin_meta;
         key_meta <= key_pins_n;
         key_sync <= key_meta;
         por_meta <= power_on_detect;
         por_sync <= por_meta;
      end
   end

   // ****************************************
   // Source filters
   // ****************************************
   wire pin_req;
   wire key_req;

   low_level_filter #(
      .LEN(PIN_CYCLES)
   ) u_pin_filter (
      .clk(clk),
      .rst_b(rst_b),
      .in_n(pin_sync),
      .enable(1'b1),
      .req(pin_req)
   );

   low_level_filter #(
      .LEN(KEY_CYCLES)
   ) u_key_filter (
      .clk(clk),
      .rst_b(rst_b),
      .in_n(|key_sync),
      .enable(key_reset_enable),
      .req(key_req)
   );

   // ****************************************
   // Group requests
   // ****************************************
   // Power-on request
   wire por_req = por_sync;
   wire svd_req = voltage_drop_detect & voltage_reset_enable;
   wire wide_req = pin_req | por_req | key_req | svd_req | watchdog_overflow;
   wire pin_power_req = pin_req | por_req;

   // ****************************************
   // Hold stage
   // ****************************************
   // Held in reset from controller reset, so boot always waits a full hold
   reg [`HOLD_CNT_W-1:0] wide_cnt;
   reg [`HOLD_CNT_W-1:0] pp_cnt;
   reg wide_held;
   reg pp_held;

   always @(posedge clk) begin
      if (!rst_b) begin
         wide_cnt <= {`HOLD_CNT_W{1'b0}};
         wide_held <= 1'b1;
      end else if (wide_req) begin
         wide_cnt <= {`HOLD_CNT_W{1'b0}};
         wide_held <= 1'b1;
      end else if (wide_held) begin
         if (wide_cnt >= HOLD_CYCLES[`HOLD_CNT_W-1:0] - 20'h00001) begin
            wide_held <= 1'b0;
         end else begin
            wide_cnt <= wide_cnt + 20'h00001;
         end
      end
   end

   // Pin and power group also holds
   always @(posedge clk) begin
      if (!rst_b) begin
         pp_cnt <= {`HOLD_CNT_W{1'b0}};
         pp_held <= 1'b1;
      end else if (pin_power_req) begin
         pp_cnt <= {`HOLD_CNT_W{1'b0}};
         pp_held <= 1'b1;
      end else if (pp_held) begin
         if (pp_cnt >= HOLD_CYCLES[`HOLD_CNT_W-1:0] - 20'h00001) begin
            pp_held <= 1'b0;
         end else begin
            pp_cnt <= pp_cnt + 20'h00001;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Soft reset per peripheral
   wire [NUM_PERIPH-1:0] sw_req =
      peripheral_soft_reset_bit | (~module_enable_bit & ENABLE_RESETS);

   always @(posedge clk) begin
      if (!rst_b) begin
         hw_reset_group_wide_n <= 1'b0;
         hw_reset_group_pin_power_n <= 1'b0;
         sw_reset_group_n <= {NUM_PERIPH{1'b0}};
      end else begin
         hw_reset_group_wide_n <= ~(wide_req | wide_held);
         hw_reset_group_pin_power_n <= ~(pin_power_req | pp_held);
         sw_reset_group_n <= ~sw_req;
      end
   end

endmodule // reset_controller

// *** rtl/reset_controller_defines.vh ***
`ifndef RESET_CONTROLLER_DEFINES_VH
`define RESET_CONTROLLER_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS 4000
// Pin filter minimum low time, ns
`define PIN_FILTER_NS 1000
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS * 1000) / `CLK_PERIOD_PS)
// Key-entry minimum low time, ns
`define KEY_FILTER_NS 2000
`define KEY_FILTER_CYCLES ((`KEY_FILTER_NS * 1000) / `CLK_PERIOD_PS)
// Reset hold time, us
`define HOLD_TIME_US 100
`define HOLD_CYCLES ((`HOLD_TIME_US * 1000000) / `CLK_PERIOD_PS)

// ****************************************
// Widths
// ****************************************
`define FILTER_CNT_W 16
`define HOLD_CNT_W 20
`define NUM_PERIPH 4

`endif

// *** rtl/low_level_filter.v ***
`timescale 1ns/1ps
`include "reset_controller_defines.vh"

// Asserts req once in_n has been low for LEN consecutive cycles
module low_level_filter #(
   parameter LEN = 250
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Filtered level
   input wire in_n,
   input wire enable,
   output reg req
);

   reg [`FILTER_CNT_W-1:0] count;

   always @(posedge clk) begin
      if (!rst_b) begin
         count <= {`FILTER_CNT_W{1'b0}};
         req <= 1'b0;
      end else if (in_n || !enable) begin
         // Any high sample discards the pulse
         count <= {`FILTER_CNT_W{1'b0}};
         req <= 1'b0;
      end else if (count >= LEN[`FILTER_CNT_W-1:0] - 16'h0001) begin
         req <= 1'b1;
      end else begin
         count <= count + 16'h0001;
      end
   end

endmodule // low_level_filter

// *** sim/reset_controller_assertions.sv ***
`timescale 1ns/1ps
module reset_controller_assertions #(parameter HOLD_CYCLES = 20, parameter NUM_PERIPH = 4) (
   // Watched ports
   input wire clk, rst_b, reset_pin_n, key_reset_enable, power_on_detect, watchdog_overflow,
   input wire voltage_drop_detect, voltage_reset_enable,
   input wire [1:0] key_pins_n,
   input wire [NUM_PERIPH-1:0] module_enable_bit, peripheral_soft_reset_bit, sw_reset_group_n,
   input wire hw_reset_group_wide_n, hw_reset_group_pin_power_n
);
   reg [7:0] low_cnt;
   // Cycles the wide group has stayed low
   always @(posedge clk) begin
      low_cnt <= (!rst_b || hw_reset_group_wide_n) ? 8'h00 : low_cnt + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_key; (key_reset_enable && key_pins_n == 2'h0) [*8]; endsequence
   property p_wd; watchdog_overflow |=> !hw_reset_group_wide_n; endproperty
   a_wd: assert property (p_wd) else $error("watchdog missed");
   property p_vd; voltage_drop_detect && voltage_reset_enable |=> !hw_reset_group_wide_n; endproperty
   a_vd: assert property (p_vd) else $error("drop missed");
   property p_sw; peripheral_soft_reset_bit[0] |=> !sw_reset_group_n[0]; endproperty
   a_sw: assert property (p_sw) else $error("soft missed");
   property p_rel; module_enable_bit[0] && !peripheral_soft_reset_bit[0] |=> sw_reset_group_n[0];
   endproperty
   a_rel: assert property (p_rel) else $error("soft held");
   property p_hold; $rose(hw_reset_group_wide_n) |-> low_cnt >= HOLD_CYCLES - 1; endproperty
   a_hold: assert property (p_hold) else $error("hold short");
   property p_sync; $rose(hw_reset_group_wide_n) |-> !$past(watchdog_overflow); endproperty
   a_sync: assert property (p_sync) else $error("early release");
   property p_por; power_on_detect |-> ##[1:4] !hw_reset_group_pin_power_n; endproperty
   a_por: assert property (p_por) else $error("power-on missed");
   property p_key; s_key |-> ##[0:2] !hw_reset_group_wide_n; endproperty
   a_key: assert property (p_key) else $error("key missed");
endmodule // reset_controller_assertions
bind reset_controller reset_controller_assertions #(.HOLD_CYCLES(HOLD_CYCLES),
   .NUM_PERIPH(NUM_PERIPH)) chk (.*);

// *** sim/reset_source_model.sv ***
`timescale 1ns/1ps
module reset_source_model (
   // Clock and sources
   input wire clk,
   output reg reset_pin_n = 1'b1,
   output reg [1:0] key_pins_n = 2'h3,
   output reg power_on_detect = 1'b0
);
   task pin_low(input integer n);
      begin
         @(posedge clk) reset_pin_n <= 1'b0;
         repeat (n) @(posedge clk);
         reset_pin_n <= 1'b1;
      end
   endtask
   task key_low(input integer n);
      begin
         @(posedge clk) key_pins_n <= 2'h0;
         repeat (n) @(posedge clk);
         key_pins_n <= 2'h3;
      end
   endtask
   task por;
      begin
         @(posedge clk) power_on_detect <= 1'b1;
         @(posedge clk) power_on_detect <= 1'b0;
      end
   endtask
endmodule // reset_source_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0;
   reg rst_b, key_en, wd, vd, vd_en;
   reg [3:0] men, sft;
   wire pin_n, por, wide_n, pp_n;
   wire [1:0] key_n;
   wire [3:0] sw_n;
   integer n_errors = 0, n_checks = 0, i;
   reg [4:0] rows [0:3];
   always #2 clk = ~clk;
   reset_source_model src (.clk(clk), .reset_pin_n(pin_n), .key_pins_n(key_n),
      .power_on_detect(por));
   reset_controller #(.HOLD_CYCLES(20), .PIN_CYCLES(4), .KEY_CYCLES(4)) DUT (.clk(clk),
      .rst_b(rst_b), .reset_pin_n(pin_n), .key_pins_n(key_n), .key_reset_enable(key_en),
      .power_on_detect(por), .watchdog_overflow(wd), .voltage_drop_detect(vd),
      .voltage_reset_enable(vd_en), .module_enable_bit(men), .peripheral_soft_reset_bit(sft),
      .hw_reset_group_wide_n(wide_n), .hw_reset_group_pin_power_n(pp_n), .sw_reset_group_n(sw_n));
   task chk(input [3:0] got, input [3:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t %h %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Two falling edges so the answer edge has landed
   task settle;
      repeat (2) @(negedge clk);
   endtask
   initial begin
      #20000;
      n_errors = n_errors + 1;
      give_verdict;
   end
   initial begin
      rst_b <= 1'b0;
      key_en <= 1'b0;
      wd <= 1'b0;
      vd <= 1'b0;
      vd_en <= 1'b0;
      men <= 4'hf;
      sft <= 4'h0;
      // Rows: watchdog, drop, drop enable, soft bit, wide group
      rows[0] = 5'h10;
      rows[1] = 5'h09;
      rows[2] = 5'h0c;
      rows[3] = 5'h03;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk) chk({wide_n, pp_n, sw_n[1:0]}, 4'h0);
      repeat (10) @(posedge clk);
      @(negedge clk) chk(wide_n, 1'b0);
      repeat (20) @(posedge clk);
      @(negedge clk) chk({wide_n, pp_n}, 2'h3);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk) {wd, vd, vd_en, sft[0]} <= rows[i][4:1];
         settle;
         chk({wide_n, sw_n[0], pp_n}, {rows[i][0], ~rows[i][1], 1'b1});
         @(posedge clk) {wd, vd, sft[0]} <= 3'h0;
         settle;
         chk(sw_n[0], 1'b1);
         repeat (30) @(posedge clk);
      end
      src.pin_low(3);
      repeat (8) @(negedge clk);
      chk(wide_n, 1'b1);
      src.pin_low(10);
      settle;
      chk({wide_n, pp_n}, 2'h0);
      repeat (40) @(posedge clk);
      src.key_low(10);
      settle;
      chk(wide_n, 1'b1);
      @(posedge clk) key_en <= 1'b1;
      src.key_low(10);
      settle;
      chk({wide_n, pp_n}, 2'h1);
      repeat (40) @(posedge clk);
      src.por;
      repeat (4) @(negedge clk);
      chk(pp_n, 1'b0);
      @(posedge clk) men <= 4'he;
      settle;
      chk(sw_n, 4'he);
      give_verdict;
   end
endmodule // testbench
